// [rtl/hs_serdes_cfg_pkg.sv]
// Constants and types of the high-speed serializer configuration register
// Contract
// - Decode PLL multiplier code; 0000,0001,1111 reserved
// - Control-two register at 0x03, 16 bits, 0xA444
// - Bits 15:12 swing code, reset 1010, table
// - Bit 10 transmitter enable, forced off by powerdown
// - Bit 2 receiver enable, forced off by powerdown
// - Bits 9:8 transmit rate divide select
// - Bits 1:0 receive rate, independent of transmit
// - Bits 7:6 gain loop attenuator mode
// - Bits 5:4 autozero calibration mode
// - Bit 11 reserved read-write, resets zero
// - PLL code at control-one bits 3:0, reset 1101
package hs_serdes_cfg_pkg;

    // ==========================================================
    // Register map (byte addresses)
    // Register numbers are word indices; byte address is four times
    localparam logic [5:0]  CTRL_GLOB_INDEX  = 6'h01;  // global power-down
    localparam logic [5:0]  CTRL_ONE_INDEX   = 6'h02;  // holds pll code
    localparam logic [5:0]  CTRL_TWO_INDEX   = 6'h03;
    localparam logic [7:0]  CTRL_ONE_OFFSET  = {CTRL_ONE_INDEX, 2'b00};
    localparam logic [7:0]  CTRL_TWO_OFFSET  = {CTRL_TWO_INDEX, 2'b00};
    localparam logic [7:0]  CTRL_GLOB_OFFSET = {CTRL_GLOB_INDEX, 2'b00};
    localparam logic [15:0] CTRL_TWO_RESET   = 16'hA444;
    localparam logic [3:0]  PLL_CODE_RESET   = 4'hD;
    localparam logic        GLOBAL_PD_RESET  = 1'b0;

    // ==========================================================
    // Field positions
    localparam int SWING_LSB   = 12;
    localparam int RSVD_BIT    = 11;
    localparam int TX_EN_BIT   = 10;
    localparam int TX_RATE_LSB = 8;
    localparam int GAIN_LSB    = 6;
    localparam int AZ_LSB      = 4;
    localparam int UNSCR_BIT   = 3;
    localparam int RX_EN_BIT   = 2;
    localparam int RX_RATE_LSB = 0;
    localparam int GLOBAL_PD_BIT = 15;

    typedef enum logic [1:0] {
        RATE_FULL, RATE_HALF, RATE_QUARTER, RATE_EIGHTH
    } rate_t;

    typedef enum logic [1:0] {
        GAIN_FREEZE_FIRST, GAIN_FREEZE_LOCKED, GAIN_FORCE_OFF, GAIN_FORCE_ON
    } gain_mode_t;

    typedef enum logic [1:0] {
        AZ_ON_RX_ENABLE, AZ_DISABLED, AZ_FORCED_UPDATE, AZ_FORCED_HOLD
    } az_mode_t;

endpackage : hs_serdes_cfg_pkg

// [rtl/hs_serdes_config_reg.sv]
// Serializer configuration register bank behind an AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none
module hs_serdes_config_reg #(
    parameter int SYNC_STAGES = 2  // depth of the power-down pin synchroniser
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic        HSEL,
    input  wire logic [7:0]  HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        CHANNEL_POWERDOWN_N,
    output logic             TX_ENABLE,
    output logic             RX_ENABLE,
    output logic      [3:0]  TX_SWING_CODE,
    output logic      [10:0] TX_SWING_MV,
    output logic      [1:0]  TX_RATE_SELECT,
    output logic      [1:0]  RX_RATE_SELECT,
    output logic      [1:0]  GAIN_LOOP_MODE,
    output logic      [1:0]  AUTOZERO_CAL_MODE,
    output logic             UNSCRAMBLED_DATA_ENABLE,
    output logic      [3:0]  PLL_MULTIPLIER_CODE,
    output logic      [7:0]  PLL_MULT_X4,
    output logic             PLL_CODE_RESERVED
);

    // ==========================================================
    // Elaboration check
    // A single flop would let a metastable pin value reach the enables
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be two or more");
    end

    // ==========================================================
    // Local aliases of the reset words
    localparam logic [15:0] TWO_RST = hs_serdes_cfg_pkg::CTRL_TWO_RESET;
    localparam logic [3:0]  PLL_RST = hs_serdes_cfg_pkg::PLL_CODE_RESET;

    // ==========================================================
    // Register select decoded from a byte address
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_CTRL_ONE,
        SEL_CTRL_TWO,
        SEL_GLOBAL
    } reg_sel_t;

    // Shared by the write path and the read path so they never disagree
    function automatic reg_sel_t reg_sel(input logic [7:0] a);
        if (a == hs_serdes_cfg_pkg::CTRL_TWO_OFFSET) begin
            reg_sel = SEL_CTRL_TWO;
        end else if (a == hs_serdes_cfg_pkg::CTRL_ONE_OFFSET) begin
            reg_sel = SEL_CTRL_ONE;
        end else if (a == hs_serdes_cfg_pkg::CTRL_GLOB_OFFSET) begin
            reg_sel = SEL_GLOBAL;
        end else begin
            reg_sel = SEL_NONE;
        end
    endfunction : reg_sel

    // ==========================================================
    // Swing code to typical amplitude in mV
    // Typical values only; the analog corner spread is not modelled
    function automatic logic [10:0] swing_mv(input logic [3:0] c);
        case (c)
            4'h0: swing_mv = 11'h082;
            4'h1: swing_mv = 11'h0DC;
            4'h2: swing_mv = 11'h12C;
            4'h3: swing_mv = 11'h186;
            4'h4: swing_mv = 11'h1E0;
            4'h5: swing_mv = 11'h23A;
            4'h6: swing_mv = 11'h294;
            4'h7: swing_mv = 11'h2EE;
            4'h8: swing_mv = 11'h33E;
            4'h9: swing_mv = 11'h3A2;
            4'hA: swing_mv = 11'h3FC;
            4'hB: swing_mv = 11'h456;
            4'hC: swing_mv = 11'h49C;
            4'hD: swing_mv = 11'h4F6;
            4'hE: swing_mv = 11'h53C;
            default: swing_mv = 11'h578;
        endcase
    endfunction : swing_mv

    // Multiplier in quarter steps, zero marks a reserved code
    // Quarter steps keep 8.25x and 16.5x exact without a fraction
    function automatic logic [7:0] pll_x4(input logic [3:0] c);
        case (c)
            4'h2: pll_x4 = 8'h10;
            4'h3: pll_x4 = 8'h14;
            4'h4: pll_x4 = 8'h18;
            4'h5: pll_x4 = 8'h20;
            4'h6: pll_x4 = 8'h21;
            4'h7: pll_x4 = 8'h28;
            4'h8: pll_x4 = 8'h30;
            4'h9: pll_x4 = 8'h32;
            4'hA: pll_x4 = 8'h3C;
            4'hB: pll_x4 = 8'h40;
            4'hC: pll_x4 = 8'h42;
            4'hD: pll_x4 = 8'h50;
            4'hE: pll_x4 = 8'h64;
            default: pll_x4 = 8'h00;
        endcase
    endfunction : pll_x4

    // ==========================================================
    // Pin synchroniser; only the last stage is read by logic
    // Resets to powered down, so enables stay low until the pin is seen
    logic [SYNC_STAGES-1:0] pd_n_pipe_r;
    logic                   pd_n_sync;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pd_n_pipe_r <= '0;
        end else begin
            pd_n_pipe_r <= {pd_n_pipe_r[SYNC_STAGES-2:0], CHANNEL_POWERDOWN_N};
        end
    end

    assign pd_n_sync = pd_n_pipe_r[SYNC_STAGES-1];

    // ==========================================================
    // Bus address phase capture; slave is always ready
    // Size is not checked: every register is one aligned word
    logic       wr_pend_r;
    logic [7:0] addr_r;
    logic       take;

    assign take = HSEL & HREADY & HTRANS[1];

    // Write flag lives for exactly one data phase
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            wr_pend_r <= 1'b0;
        end else begin
            wr_pend_r <= take & HWRITE;
        end
    end

    // Address kept for the data phase, where write data arrives
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            addr_r <= 8'h00;
        end else if (take) begin
            addr_r <= HADDR;
        end
    end

    // ==========================================================
    // Register storage
    // Stored bits change only by writes, never by power-down
    logic [15:0] ctrl_two_r;
    logic [3:0]  pll_code_r;
    logic        global_pd_r;
    reg_sel_t    wr_sel;

    assign wr_sel = reg_sel(addr_r);

    // Control-two word, all sixteen bits read-write
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            ctrl_two_r <= TWO_RST;
        end else if (wr_pend_r && wr_sel == SEL_CTRL_TWO) begin
            ctrl_two_r <= HWDATA[15:0];
        end
    end

    // Multiplier code; other control-one bits are not kept here
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pll_code_r <= PLL_RST;
        end else if (wr_pend_r && wr_sel == SEL_CTRL_ONE) begin
            pll_code_r <= HWDATA[3:0];
        end
    end

    // Global power-down bit of the first register
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            global_pd_r <= hs_serdes_cfg_pkg::GLOBAL_PD_RESET;
        end else if (wr_pend_r && wr_sel == SEL_GLOBAL) begin
            global_pd_r <= HWDATA[hs_serdes_cfg_pkg::GLOBAL_PD_BIT];
        end
    end

    // ==========================================================
    // Read data, registered; unmapped reads return zero
    logic [31:0] rd_nxt;
    reg_sel_t    rd_sel;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        rd_sel = reg_sel(HADDR);
        if (rd_sel == SEL_CTRL_TWO) begin
            rd_nxt = {16'h0000, ctrl_two_r};
        end else if (rd_sel == SEL_CTRL_ONE) begin
            rd_nxt = {28'h0000000, pll_code_r};
        end else if (rd_sel == SEL_GLOBAL) begin
            rd_nxt = {16'h0000, global_pd_r, 15'h0000};
        end
    end

    // Read after a same-address write in the next cycle sees old data
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            HRDATA <= 32'h0000_0000;
        end else begin
            HRDATA <= (take & ~HWRITE) ? rd_nxt : 32'h0000_0000;
        end
    end

    // No wait states: storage answers in one cycle
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            HREADYOUT <= 1'b1;
        end else begin
            HREADYOUT <= 1'b1;
        end
    end

    // Unmapped addresses are ignored, so there is never an error
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            HRESP <= 1'b0;
        end else begin
            HRESP <= 1'b0;
        end
    end

    // ==========================================================
    // Gated enables
    // Either power-down source wins over the stored enable bits
    logic pd_active;

    assign pd_active = ~pd_n_sync | global_pd_r;

    // Transmitter enable
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            TX_ENABLE <= 1'b0;
        end else begin
            TX_ENABLE <= ctrl_two_r[hs_serdes_cfg_pkg::TX_EN_BIT]
                         & ~pd_active;
        end
    end

    // Receiver enable
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            RX_ENABLE <= 1'b0;
        end else begin
            RX_ENABLE <= ctrl_two_r[hs_serdes_cfg_pkg::RX_EN_BIT]
                         & ~pd_active;
        end
    end

    // ==========================================================
    // Field views of the stored word
    logic [3:0]                   swing_f;
    logic [3:0]                   swing_rst;
    hs_serdes_cfg_pkg::rate_t     tx_rate_f;
    hs_serdes_cfg_pkg::rate_t     rx_rate_f;
    hs_serdes_cfg_pkg::gain_mode_t gain_f;
    hs_serdes_cfg_pkg::az_mode_t  az_f;

    assign swing_f   = ctrl_two_r[hs_serdes_cfg_pkg::SWING_LSB +: 4];
    assign swing_rst = TWO_RST[hs_serdes_cfg_pkg::SWING_LSB +: 4];
    assign tx_rate_f = hs_serdes_cfg_pkg::rate_t'(
        ctrl_two_r[hs_serdes_cfg_pkg::TX_RATE_LSB +: 2]);
    assign rx_rate_f = hs_serdes_cfg_pkg::rate_t'(
        ctrl_two_r[hs_serdes_cfg_pkg::RX_RATE_LSB +: 2]);
    assign gain_f    = hs_serdes_cfg_pkg::gain_mode_t'(
        ctrl_two_r[hs_serdes_cfg_pkg::GAIN_LSB +: 2]);
    assign az_f      = hs_serdes_cfg_pkg::az_mode_t'(
        ctrl_two_r[hs_serdes_cfg_pkg::AZ_LSB +: 2]);

    // ==========================================================
    // Decoded settings, each registered one cycle behind the word
    // Output swing code and its amplitude
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            TX_SWING_CODE <= swing_rst;
            TX_SWING_MV   <= swing_mv(swing_rst);
        end else begin
            TX_SWING_CODE <= swing_f;
            TX_SWING_MV   <= swing_mv(swing_f);
        end
    end

    // Line rates; the two directions are fully independent
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            TX_RATE_SELECT <= TWO_RST[hs_serdes_cfg_pkg::TX_RATE_LSB +: 2];
            RX_RATE_SELECT <= TWO_RST[hs_serdes_cfg_pkg::RX_RATE_LSB +: 2];
        end else begin
            TX_RATE_SELECT <= tx_rate_f;
            RX_RATE_SELECT <= rx_rate_f;
        end
    end

    // Receiver loop modes
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            GAIN_LOOP_MODE    <= TWO_RST[hs_serdes_cfg_pkg::GAIN_LSB +: 2];
            AUTOZERO_CAL_MODE <= TWO_RST[hs_serdes_cfg_pkg::AZ_LSB +: 2];
        end else begin
            GAIN_LOOP_MODE    <= gain_f;
            AUTOZERO_CAL_MODE <= az_f;
        end
    end

    // Unscrambled data option; choosing it per rate is up to software
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            UNSCRAMBLED_DATA_ENABLE <= TWO_RST[hs_serdes_cfg_pkg::UNSCR_BIT];
        end else begin
            UNSCRAMBLED_DATA_ENABLE <= ctrl_two_r[hs_serdes_cfg_pkg::UNSCR_BIT];
        end
    end

    // Multiplier code, its value in quarter steps and the reserved flag
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            PLL_MULTIPLIER_CODE <= PLL_RST;
            PLL_MULT_X4         <= pll_x4(PLL_RST);
            PLL_CODE_RESERVED   <= (pll_x4(PLL_RST) == 8'h00);
        end else begin
            PLL_MULTIPLIER_CODE <= pll_code_r;
            PLL_MULT_X4         <= pll_x4(pll_code_r);
            PLL_CODE_RESERVED   <= (pll_x4(pll_code_r) == 8'h00);
        end
    end

endmodule : hs_serdes_config_reg
`default_nettype wire

// [verif/hs_serdes_config_reg_assertions.sv]
// Assertion checker for the serializer configuration register bank
`timescale 1ns/100ps
`default_nettype none
module hs_serdes_cfg_checker (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        HSEL,
    input wire logic [7:0]  HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        CHANNEL_POWERDOWN_N,
    input wire logic        TX_ENABLE,
    input wire logic        RX_ENABLE,
    input wire logic [1:0]  TX_RATE_SELECT,
    input wire logic [3:0]  PLL_MULTIPLIER_CODE,
    input wire logic [7:0]  PLL_MULT_X4,
    input wire logic        PLL_CODE_RESERVED
);
    // =========================================================
    // Bus answers, gating and decode
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    a_ready_always: assert property (HREADYOUT)
        else $error("slave inserted a wait state");
    a_resp_okay: assert property (!HRESP)
        else $error("slave answered with an error");
    a_rdata_idle: assert property (
        !$past(HSEL && HREADY && HTRANS[1] && !HWRITE) |-> HRDATA == 32'h0)
        else $error("read data outside a read data phase");
    // Pin passes two sync flops and an output flop before it bites
    a_tx_gated: assert property (!CHANNEL_POWERDOWN_N [*4] |-> !TX_ENABLE)
        else $error("transmitter on during power-down");
    a_rx_gated: assert property (!CHANNEL_POWERDOWN_N [*4] |-> !RX_ENABLE)
        else $error("receiver on during power-down");
    // Decode is registered with the code; still only judge a code held two samples
    a_pll_reserved: assert property ($stable(PLL_MULTIPLIER_CODE) [*2] |->
        PLL_CODE_RESERVED == (PLL_MULTIPLIER_CODE inside {4'h0, 4'h1, 4'hF}))
        else $error("reserved flag disagrees with pll code");
    a_pll_fraction: assert property (
        ($stable(PLL_MULTIPLIER_CODE) && PLL_MULTIPLIER_CODE == 4'h6) [*2]
        |-> PLL_MULT_X4 == 8'h21)
        else $error("pll code 0110 not decoded as 8.25x");
    a_write_lands: assert property (
        HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == 8'h0C
        |-> ##3 TX_RATE_SELECT == $past(HWDATA[9:8], 2))
        else $error("transmit rate did not follow a write");
endmodule : hs_serdes_cfg_checker
bind hs_serdes_config_reg hs_serdes_cfg_checker u_chk (.*);
`default_nettype wire

// [verif/hs_serdes_config_reg_tb_top.sv]
// Self-checking bench for the serializer configuration register bank
`timescale 1ns/100ps
`default_nettype none
module hs_serdes_config_reg_tb_top;
    // =========================================================
    // Signals and expected tables
    logic        REF_CLK, RESET, HSEL, HWRITE, HREADYOUT, HRESP;
    logic        CHANNEL_POWERDOWN_N, TX_ENABLE, RX_ENABLE;
    logic        UNSCRAMBLED_DATA_ENABLE, PLL_CODE_RESERVED;
    logic [1:0]  HTRANS, TX_RATE_SELECT, RX_RATE_SELECT;
    logic [1:0]  GAIN_LOOP_MODE, AUTOZERO_CAL_MODE;
    logic [2:0]  HSIZE;
    logic [3:0]  TX_SWING_CODE, PLL_MULTIPLIER_CODE;
    logic [7:0]  HADDR, PLL_MULT_X4;
    logic [10:0] TX_SWING_MV;
    logic [15:0] v;
    logic [31:0] HWDATA, HRDATA, q;
    wire logic   HREADY = HREADYOUT;
    int          n_mismatch = 0;
    int          n_tests = 0;
    logic [10:0] mv_tbl [16] = '{11'h082, 11'h0DC, 11'h12C, 11'h186,
        11'h1E0, 11'h23A, 11'h294, 11'h2EE, 11'h33E, 11'h3A2, 11'h3FC,
        11'h456, 11'h49C, 11'h4F6, 11'h53C, 11'h578};
    logic [7:0]  x4_tbl [16] = '{8'h00, 8'h00, 8'h10, 8'h14, 8'h18, 8'h20,
        8'h21, 8'h28, 8'h30, 8'h32, 8'h3C, 8'h40, 8'h42, 8'h50, 8'h64, 8'h00};

    always #25 REF_CLK = ~REF_CLK;
    hs_serdes_config_reg DUT (.*);

    // =========================================================
    // Bus master, compare and verdict
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        HSEL   <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR  <= a;
        do @(posedge REF_CLK); while (HREADY !== 1'b1);
        HSEL   <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge REF_CLK); while (HREADY !== 1'b1);
        q = HRDATA;
    endtask : bus
    // Outputs trail the register by a flop, so give them time
    task automatic settle;
        repeat (4) @(posedge REF_CLK);
    endtask : settle
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string nm);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("compares %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // Watchdog well past the few hundred cycles the tests need
    initial begin
        repeat (3000) @(posedge REF_CLK);
        n_mismatch++;
        final_report();
    end

    initial begin
        {REF_CLK, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
        {RESET, CHANNEL_POWERDOWN_N} = 2'h3;
        HSIZE = 3'h2;
        repeat (5) @(posedge REF_CLK);
        RESET <= 1'b0;
        bus(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h0000A444, "ctrl_two_reset");
        bus(1'b0, 8'h08, 32'h0);
        chk(q, 32'h0000000D, "pll_reset");
        settle;
        chk(32'(TX_SWING_MV), 32'h3FC, "swing_reset");
        chk(32'({TX_ENABLE, RX_ENABLE, GAIN_LOOP_MODE, AUTOZERO_CAL_MODE}),
            32'h34, "mode_reset");
        // Every code of swing and pll, rates and modes cycled alongside
        for (int i = 0; i < 16; i++) begin
            // Unscrambled data only off at full receive rate
            v = {i[3:0], i[0], i[0], i[1:0], i[1:0], i[1:0], ~&i[1:0],
                 i[0], ~i[1:0]};
            bus(1'b1, 8'h08, 32'(i));
            bus(1'b1, 8'h0C, {16'h0, v});
            settle;
            bus(1'b0, 8'h0C, 32'h0);
            chk(q, {16'h0, v}, "readback");
            chk(32'(TX_SWING_MV), 32'(mv_tbl[i]), "swing_mv");
            chk(32'(PLL_MULT_X4), 32'(x4_tbl[i]), "pll_x4");
            chk(32'({PLL_CODE_RESERVED, TX_ENABLE, RX_ENABLE,
                UNSCRAMBLED_DATA_ENABLE}), 32'({i < 2 || i == 15,
                i[0], i[0], ~&i[1:0]}), "flags");
            chk(32'({TX_RATE_SELECT, RX_RATE_SELECT, GAIN_LOOP_MODE,
                AUTOZERO_CAL_MODE, TX_SWING_CODE}), 32'({i[1:0], ~i[1:0],
                i[1:0], i[1:0], i[3:0]}), "fields");
        end
        CHANNEL_POWERDOWN_N <= 1'b0;
        settle;
        chk(32'({TX_ENABLE, RX_ENABLE}), 32'h0, "pin_pd");
        CHANNEL_POWERDOWN_N <= 1'b1;
        bus(1'b1, 8'h04, 32'h00008000);
        settle;
        chk(32'({TX_ENABLE, RX_ENABLE}), 32'h0, "global_pd");
        bus(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h0000FFF4, "bits_kept");
        bus(1'b1, 8'h04, 32'h0);
        bus(1'b1, 8'h10, 32'h0000FFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0, "unmapped");
        settle;
        chk(32'({TX_ENABLE, RX_ENABLE}), 32'h3, "pd_lifted");
        final_report();
    end
endmodule : hs_serdes_config_reg_tb_top
`default_nettype wire
